/* pkg/spp_pkg.sv */
// Package for the shared-pin parallel port: widths, reset values, pin mask, direction encoding.
// Assumes a single system clock domain; no bus, registers reach via ports.
package spp_pkg;
   // Default port width in pins
   localparam int          SPP_WIDTH_DEF   = 16;
   // Direction reset: all ones makes every pin an input
   localparam logic [15:0] SPP_DIR_RST     = 16'hFFFF;
   // Analog select reset: all pins start analog
   localparam logic [15:0] SPP_ANSEL_RST   = 16'hFFFF;
   // Latch and open-drain reset values
   localparam logic [15:0] SPP_LAT_RST     = 16'h0000;
   localparam logic [15:0] SPP_ODC_RST     = 16'h0000;
   // Bit mask of pins that exist on this device (all by default)
   localparam logic [15:0] SPP_VALID_DEF   = 16'hFFFF;
   // Direction bit encoding
   localparam logic        SPP_DIR_IN      = 1'b1;
endpackage

/* core/spp_port.sv */
// Shared-pin parallel port: direction, latch, open-drain, analog select,
// pin read path and the peripheral/port output multiplexer pair per pin.
// Assumes pin inputs asynchronous to ref_clk, writes are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module spp_port
   import spp_pkg::*;
#(
   parameter int          WIDTH = SPP_WIDTH_DEF,
   parameter logic [15:0] VALID = SPP_VALID_DEF
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Software write strobes and data
   input  wire logic             dir_wr,
   input  wire logic             lat_wr,
   input  wire logic             port_wr,
   input  wire logic             odc_wr,
   input  wire logic             ansel_wr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Software read views
   output var  logic [WIDTH-1:0] dir_rd,
   output var  logic [WIDTH-1:0] lat_rd,
   output var  logic [WIDTH-1:0] port_rd,
   output var  logic [WIDTH-1:0] odc_rd,
   output var  logic [WIDTH-1:0] ansel_rd,
   // Sharing peripheral side
   input  wire logic [WIDTH-1:0] periph_en,
   input  wire logic [WIDTH-1:0] periph_drive,
   input  wire logic [WIDTH-1:0] periph_out,
   output var  logic [WIDTH-1:0] periph_in,
   // Pin side: output enable low while driving
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_out,
   output var  logic [WIDTH-1:0] pin_oe_b
);

   // Mask of implemented bits, cut to the port width
   localparam logic [WIDTH-1:0] VMASK = VALID[WIDTH-1:0];

   logic [WIDTH-1:0] dir_q;     // Direction, one = input
   logic [WIDTH-1:0] lat_q;     // Output latch
   logic [WIDTH-1:0] odc_q;     // Open-drain select
   logic [WIDTH-1:0] ansel_q;   // Analog select
   logic [WIDTH-1:0] sync1_q;   // First synchroniser stage
   logic [WIDTH-1:0] sync2_q;   // Settled pin sample
   logic [WIDTH-1:0] oe_b_d;    // Next output enable, active low
   logic [WIDTH-1:0] out_d;     // Next pin data

   // Direction register; reset forces all inputs
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         dir_q <= SPP_DIR_RST[WIDTH-1:0];
      else if (dir_wr)
         dir_q <= wr_data & VMASK | ~VMASK;
   end

   // Latch is written from either the latch or the port address
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         lat_q <= SPP_LAT_RST[WIDTH-1:0];
      else if (lat_wr || port_wr)
         lat_q <= wr_data & VMASK;
   end

   // Open-drain select
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         odc_q <= SPP_ODC_RST[WIDTH-1:0];
      else if (odc_wr)
         odc_q <= wr_data & VMASK;
   end

   // Analog select starts every implemented pin analog
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ansel_q <= SPP_ANSEL_RST[WIDTH-1:0] & VMASK;
      else if (ansel_wr)
         ansel_q <= wr_data & VMASK;
   end

   // Two-stage pin synchroniser; only sync2 is looked at
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Per-pin output multiplexer pair and open-drain shaping
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_pin
         always_comb
         begin
            if (!VMASK[g])
            begin
               // Missing pin: driver held off
               oe_b_d[g] = 1'b1;
               out_d[g]  = 1'b0;
            end
            else if (periph_en[g] && periph_drive[g])
            begin
               // Peripheral owns data and enable; port driver off
               oe_b_d[g] = 1'b0;
               out_d[g]  = periph_out[g];
            end
            else if (dir_q[g] == SPP_DIR_IN)
            begin
               oe_b_d[g] = 1'b1;
               out_d[g]  = 1'b0;
            end
            else if (odc_q[g])
            begin
               // Open drain: drive only a low, release a high
               oe_b_d[g] = lat_q[g];
               out_d[g]  = 1'b0;
            end
            else
            begin
               oe_b_d[g] = 1'b0;
               out_d[g]  = lat_q[g];
            end
         end
      end
   endgenerate

   // Pin drive registered so outputs come straight from flops
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         pin_oe_b <= '1;
         pin_out  <= '0;
      end
      else
      begin
         pin_oe_b <= oe_b_d;
         pin_out  <= out_d;
      end
   end

   // Peripheral input sees the pin only while the port is not driving,
   // so the latch reaches the peripheral only from samples in flight, for three cycles after the port stops driving
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         periph_in <= '0;
      else
         periph_in <= sync2_q & VMASK & ~ansel_q
                      & (dir_q | (periph_en & periph_drive));
   end

   // Read views; is software's job: reads lag writes by two cycles
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         dir_rd   <= SPP_DIR_RST[WIDTH-1:0] & VMASK;
         lat_rd   <= '0;
         port_rd  <= '0;
         odc_rd   <= '0;
         ansel_rd <= SPP_ANSEL_RST[WIDTH-1:0] & VMASK;
      end
      else
      begin
         dir_rd   <= dir_q & VMASK;
         lat_rd   <= lat_q;
         port_rd  <= sync2_q & VMASK & ~ansel_q;
         odc_rd   <= odc_q;
         ansel_rd <= ansel_q;
      end
   end

   // Assertions
   AST_RST_INPUT: assert property (@(posedge ref_clk)
      !rst_b |=> (dir_q == SPP_DIR_RST[WIDTH-1:0]))
      else $error("direction not all inputs after reset");
   AST_ANSEL_RST: assert property (@(posedge ref_clk)
      !rst_b |=> (ansel_q == (SPP_ANSEL_RST[WIDTH-1:0] & VMASK)))
      else $error("analog select not all ones after reset");
   AST_LAT_WR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      lat_wr |=> ##1 (lat_rd == ($past(wr_data, 2) & VMASK)))
      else $error("latch read differs from written data");
   AST_PORT_WR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (port_wr && !lat_wr) |=> (lat_q == ($past(wr_data) & VMASK)))
      else $error("port write did not reach latch");
   AST_PERIPH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (periph_en[0] && periph_drive[0] && VMASK[0])
      |=> (!pin_oe_b[0] && pin_out[0] == $past(periph_out[0])))
      else $error("peripheral lost ownership of pin");
   AST_DIR_IN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (dir_q[0] && !(periph_en[0] && periph_drive[0]))
      |=> pin_oe_b[0])
      else $error("input pin driven");
   AST_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (odc_q[0] && !dir_q[0] && !(periph_en[0] && periph_drive[0]))
      |=> (pin_out[0] == 1'b0 && pin_oe_b[0] == $past(lat_q[0])))
      else $error("open-drain pin drove high");
   AST_ANALOG: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ansel_q[0] |=> !port_rd[0])
      else $error("analog pin read non-zero");
   AST_LOOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!dir_q[0] && !(periph_en[0] && periph_drive[0]))
      |=> !periph_in[0])
      else $error("port output looped into peripheral");
   // Read view at the next edge is built from this edge's analog select,
   // so only that one value has to be digital for the sample to show
   AST_PIN_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!ansel_q[0] && VMASK[0])
      |=> (port_rd[0] == $past(pin_in[0], 3)))
      else $error("pin read not synchronised sample");

endmodule
`default_nettype wire

/* verification/spp_pin_model.sv */
// Model of the board around the port: outside driver and pull-up.
// Assumes the port's enable is active low and wins over the outside.
`timescale 1ns/1ps
`default_nettype none
module spp_pin_model
(
   // Port drive
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe_b,
   // Outside driver
   input  wire logic [15:0] ext_v,
   input  wire logic [15:0] ext_e,
   // Resolved pin level
   output var  logic [15:0] lvl
);
   // A pin released by both port and outside driver floats up to the pull-up, never a stale value
   always_comb
   begin
      lvl = (~pin_oe_b & pin_out) | (pin_oe_b & (~ext_e | ext_v));
   end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Random and corner tests of the shared-pin port, top pin unbonded.
// Assumes the pin model for pin levels; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import spp_pkg::*;
;
   localparam logic [15:0] V = 16'h7FFF; // Top pin left out
   logic        ref_clk, rst_b;
   logic [4:0]  stb; // Write strobes: dir, lat, port, odc, ansel
   logic [15:0] wr_data, pe, pd, po, ext_v, ext_e, lvl, p_in;
   logic [15:0] dir_rd, lat_rd, port_rd, odc_rd, ansel_rd, pin_out, oe_b;
   logic [15:0] d, l, o, a, act, eoe, eout, elv; // Expected state
   int          fail_count, num_checks;

   spp_port #(.WIDTH(16), .VALID(V)) u_dut (.ref_clk(ref_clk),
      .rst_b(rst_b), .dir_wr(stb[4]), .lat_wr(stb[3]), .port_wr(stb[2]),
      .odc_wr(stb[1]), .ansel_wr(stb[0]), .wr_data(wr_data),
      .dir_rd(dir_rd), .lat_rd(lat_rd), .port_rd(port_rd),
      .odc_rd(odc_rd), .ansel_rd(ansel_rd), .periph_en(pe),
      .periph_drive(pd), .periph_out(po), .periph_in(p_in),
      .pin_in(lvl), .pin_out(pin_out), .pin_oe_b(oe_b));
   spp_pin_model u_pins (.pin_out(pin_out), .pin_oe_b(oe_b),
      .ext_v(ext_v), .ext_e(ext_e), .lvl(lvl));

   // 40 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Compare one 16-bit result
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
   begin
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask

   // Write strobe set at a falling edge for one cycle; the next write or
   // the caller replaces it, so each strobe is assigned once per step
   task automatic wr(input logic [4:0] m, input logic [15:0] v);
   begin
      stb = m;
      wr_data = v;
      @(negedge ref_clk);
   end
   endtask

   // Counts and verdict
   task automatic end_sim;
   begin
      $display("checks=%0d fails=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask

   // Hang guard, far beyond the 40 tests of about 10 cycles
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      $display("FAIL t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
      end_sim();
   end

   initial
   begin
      {rst_b, stb} = '0;
      {wr_data, pe, pd, po, ext_v, ext_e} = '0;
      fail_count = 0;
      num_checks = 0;
      void'($urandom(32'hE84D32D7));
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      @(negedge ref_clk);
      chk(dir_rd, V);
      chk(ansel_rd, V);
      chk(oe_b, 16'hFFFF);
      for (int i = 0; i < 40; i++)
      begin
         {d, l, o, a} = {$urandom, $urandom};
         {pe, pd, po, ext_v} = {$urandom, $urandom};
         ext_e = 16'($urandom);
         // First three: all peripheral-driven, all latch-driven, all open-drain
         if (i < 3)
         begin
            {d, a, pe} = {32'h0, 16'hFFFF};
            pd = {16{i == 0}};
            o = {16{i == 2}};
         end
         wr(5'h10, d);
         wr(5'h01, a);
         wr(5'h02, o);
         if (i[0])
            wr(5'h04, l);
         else
            wr(5'h08, l);
         stb = 5'h00;
         // Wait covers read-back gap and the input synchroniser
         repeat (6) @(negedge ref_clk);
         act = pe & pd & V;
         eoe = ~V | (~act & (d | (o & l)));
         eout = (act & po) | (~act & l);
         elv = (~eoe & eout) | (eoe & (~ext_e | ext_v));
         chk(dir_rd, d & V);
         chk(lat_rd, l & V);
         chk(odc_rd, o & V);
         chk(ansel_rd, a & V);
         chk(oe_b, eoe);
         chk(pin_out & ~eoe, eout & ~eoe);
         chk(port_rd, elv & ~a & V);
         // Any port-driven output pin, open-drain release too, is kept off
         chk(p_in & V, elv & ~a & V & (act | d));
         $display("test %0d done", i);
      end
      end_sim();
   end
endmodule
`default_nettype wire
